// >>> verilog/flash_host_pkg.sv
// Constants, command codes and timing for the parallel flash host
package flash_host_pkg;

  // Register offsets on the control bus
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_ADDR   = 8'h04;
  localparam logic [7:0] OFF_WDATA  = 8'h08;
  localparam logic [7:0] OFF_RDATA  = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;

  // Field positions
  localparam int CTRL_CMD_LSB   = 0;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_IDMODE_BIT = 1;

  // Reset values
  localparam logic [15:0] ADDR_RESET  = 16'h0000;
  localparam logic [15:0] WDATA_RESET = 16'h0000;

  // Unlock addresses and command bytes
  localparam logic [15:0] UNLOCK_ADDR1 = 16'h5555;
  localparam logic [15:0] UNLOCK_ADDR2 = 16'h2AAA;
  localparam logic [7:0]  UNLOCK_DATA1 = 8'hAA;
  localparam logic [7:0]  UNLOCK_DATA2 = 8'h55;
  localparam logic [7:0]  CODE_PROGRAM = 8'hA0;
  localparam logic [7:0]  CODE_ERASE   = 8'h80;
  localparam logic [7:0]  CODE_CHIP    = 8'h10;
  localparam logic [7:0]  CODE_MAIN    = 8'h30;
  localparam logic [7:0]  CODE_LOCK    = 8'h40;
  localparam logic [7:0]  CODE_ID_IN   = 8'h90;
  localparam logic [7:0]  CODE_ID_OUT  = 8'hF0;

  // Host commands as written into the control register
  typedef enum logic [2:0] {
    CMD_READ       = 3'h0,
    CMD_PROGRAM    = 3'h1,
    CMD_CHIP_ERASE = 3'h2,
    CMD_MAIN_ERASE = 3'h3,
    CMD_LOCKOUT    = 3'h4,
    CMD_ID_ENTRY   = 3'h5,
    CMD_ID_EXIT    = 3'h6,
    CMD_ID_EXIT1   = 3'h7
  } cmd_type;

  // Timing: figures as printed, cycles derived from the clock
  localparam int CLK_PERIOD_NS  = 100;
  localparam int T_WE_LOW_NS    = 200;
  localparam int T_WE_HIGH_NS   = 200;
  localparam int T_READ_NS      = 90;
  localparam int T_ID_PAUSE_US  = 20;
  localparam int T_LOCK_PAUSE_S = 1;

  function automatic int cyc_ceil(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_ceil

  localparam int WE_LOW_CYC   = cyc_ceil(T_WE_LOW_NS);
  localparam int WE_HIGH_CYC  = cyc_ceil(T_WE_HIGH_NS);
  localparam int READ_CYC     = cyc_ceil(T_READ_NS) + 1;
  localparam int ID_PAUSE_CYC = cyc_ceil(T_ID_PAUSE_US * 1000);
  localparam int LOCK_PAUSE_CYC = T_LOCK_PAUSE_S * (1000000000 / CLK_PERIOD_NS);

endpackage : flash_host_pkg

// >>> verilog/flash_host.sv
// APB-controlled host that runs command sequences on a parallel NOR flash
// Summary of operation
// - Word program is AA@5555, 55@2AAA, A0@5555, then address and word.
// - Whole erase is six writes ending with 10 at 5555.
// - Main-array erase is the same six writes ending with 30.
// - Lockout set ends with 40 at 5555; host then idles one second.
// - Identification entry ends with 90 at 5555; host waits 20 us.
// - Identification exit ends with F0 at 5555, or is one F0 at the address register's address; host waits 20 us.
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
module flash_host
  import flash_host_pkg::*;
#(
  parameter int LOCK_PAUSE = LOCK_PAUSE_CYC
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic [15:0]      flash_addr_o,
  output logic [15:0]      flash_dq_o,
  input  wire logic [15:0] flash_dq_i,
  output logic             flash_dq_oe_n_o,
  output logic             flash_ce_n_o,
  output logic             flash_oe_n_o,
  output logic             flash_we_n_o
);

  typedef enum logic [2:0] {
    S_IDLE, S_WSETUP, S_WPULSE, S_WREC, S_RACC, S_PAUSE
  } state_type;

  state_type   state_q, state_d;
  cmd_type     cmd_q, cmd_d;
  logic [2:0]  step_q, step_d;
  logic [23:0] cnt_q, cnt_d;
  logic [15:0] addr_q, wdata_q, rdata_q;
  logic        idmode_q;
  logic [31:0] prdata_q;
  logic        wr_acc, busy, start, bad_addr, refuse;
  logic [31:0] step_word;

  // Index of the last bus write in each write command (one less than the count); read, which makes no write, gives 0
  function automatic logic [2:0] last_step(input cmd_type c);
    unique case (c)
      CMD_PROGRAM:                      return 3'h3;
      CMD_CHIP_ERASE, CMD_MAIN_ERASE,
      CMD_LOCKOUT:                      return 3'h5;
      CMD_ID_ENTRY, CMD_ID_EXIT:        return 3'h2;
      CMD_READ, CMD_ID_EXIT1:           return 3'h0;
    endcase
  endfunction : last_step

  // Address and data of one write step, as {addr, data}
  function automatic logic [31:0] seq_word(input cmd_type c,
                                           input logic [2:0] i,
                                           input logic [15:0] a,
                                           input logic [15:0] d);
    logic [7:0] fin;
    fin = CODE_ID_OUT;
    unique case (c)
      CMD_CHIP_ERASE: fin = CODE_CHIP;
      CMD_MAIN_ERASE: fin = CODE_MAIN;
      CMD_LOCKOUT:    fin = CODE_LOCK;
      CMD_ID_ENTRY:   fin = CODE_ID_IN;
      CMD_PROGRAM:    fin = CODE_PROGRAM;
      default:        fin = CODE_ID_OUT;
    endcase
    if (c == CMD_ID_EXIT1)
      return {a, 8'h00, CODE_ID_OUT};
    if (c == CMD_PROGRAM && i == 3'h3)
      return {a, d};
    unique case (i)
      3'h0, 3'h3: return {UNLOCK_ADDR1, 8'h00, UNLOCK_DATA1};
      3'h1, 3'h4: return {UNLOCK_ADDR2, 8'h00, UNLOCK_DATA2};
      3'h2: begin
        if (c == CMD_PROGRAM || c == CMD_ID_ENTRY || c == CMD_ID_EXIT)
          return {UNLOCK_ADDR1, 8'h00, fin};
        return {UNLOCK_ADDR1, 8'h00, CODE_ERASE};
      end
      default: return {UNLOCK_ADDR1, 8'h00, fin};
    endcase
  endfunction : seq_word

  // Bus decode; answers with no wait state
  assign busy     = (state_q != S_IDLE);
  assign wr_acc   = psel_i && penable_i && pwrite_i;
  assign bad_addr = !(paddr_i == OFF_CTRL || paddr_i == OFF_ADDR ||
                      paddr_i == OFF_WDATA || paddr_i == OFF_RDATA ||
                      paddr_i == OFF_STATUS);
  // A new command while one runs is refused rather than queued
  assign refuse   = wr_acc && paddr_i == OFF_CTRL && busy;
  assign start    = wr_acc && paddr_i == OFF_CTRL && !busy;
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && (bad_addr || refuse);
  assign prdata_o  = prdata_q;

  // Read data captured in the setup cycle
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      unique case (paddr_i)
        OFF_CTRL:   prdata_q <= {29'h0, cmd_q};
        OFF_ADDR:   prdata_q <= {16'h0000, addr_q};
        OFF_WDATA:  prdata_q <= {16'h0000, wdata_q};
        OFF_RDATA:  prdata_q <= {16'h0000, rdata_q};
        OFF_STATUS: prdata_q <= {30'h0, idmode_q, busy};
        default:    prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Address and write-data registers
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_q  <= ADDR_RESET;
      wdata_q <= WDATA_RESET;
    end else if (wr_acc && !busy) begin
      if (paddr_i == OFF_ADDR)
        addr_q <= pwdata_i[15:0];
      if (paddr_i == OFF_WDATA)
        wdata_q <= pwdata_i[15:0];
    end
  end

  // Command latch
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i)
      cmd_q <= CMD_READ;
    else if (start)
      cmd_q <= cmd_type'(pwdata_i[CTRL_CMD_LSB +: 3]);
  end

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    step_d  = step_q;
    cnt_d   = (cnt_q != 24'h000000) ? cnt_q - 24'h000001 : cnt_q;
    unique case (state_q)
      S_IDLE: begin
        step_d = 3'h0;
        if (start) begin
          if (cmd_type'(pwdata_i[CTRL_CMD_LSB +: 3]) == CMD_READ) begin
            state_d = S_RACC;
            cnt_d   = 24'(READ_CYC - 1);
          end else begin
            state_d = S_WSETUP;
          end
        end
      end
      S_WSETUP: begin
        state_d = S_WPULSE;
        cnt_d   = 24'(WE_LOW_CYC - 1);
      end
      S_WPULSE: begin
        if (cnt_q == 24'h000000) begin
          state_d = S_WREC;
          cnt_d   = 24'(WE_HIGH_CYC - 1);
        end
      end
      S_WREC: begin
        if (cnt_q == 24'h000000) begin
          if (step_q != last_step(cmd_q)) begin
            step_d  = step_q + 3'h1;
            state_d = S_WSETUP;
          end else if (cmd_q == CMD_LOCKOUT) begin
            state_d = S_PAUSE;
            cnt_d   = 24'(LOCK_PAUSE - 1);
          end else if (cmd_q == CMD_ID_ENTRY || cmd_q == CMD_ID_EXIT ||
                       cmd_q == CMD_ID_EXIT1) begin
            state_d = S_PAUSE;
            cnt_d   = 24'(ID_PAUSE_CYC - 1);
          end else begin
            // Program and erase end here; software polls with reads
            state_d = S_IDLE;
          end
        end
      end
      S_RACC: begin
        if (cnt_q == 24'h000000)
          state_d = S_IDLE;
      end
      S_PAUSE: begin
        if (cnt_q == 24'h000000)
          state_d = S_IDLE;
      end
      default: state_d = S_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= S_IDLE;
      step_q  <= 3'h0;
      cnt_q   <= 24'h000000;
    end else begin
      state_q <= state_d;
      step_q  <= step_d;
      cnt_q   <= cnt_d;
    end
  end

  // The first step is built at the start edge, before the latch holds
  // the new command, so the word must come from the incoming command
  assign cmd_d     = start ? cmd_type'(pwdata_i[CTRL_CMD_LSB +: 3]) : cmd_q;
  assign step_word = seq_word(cmd_d, step_d, addr_q, wdata_q);

  // Pin drivers registered from the next state, so pins never glitch.
  // Output-gate stays high on writes and chip-select drops before the
  // write strobe, so no write is lost to the inhibit conditions.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      flash_ce_n_o    <= 1'b1;
      flash_oe_n_o    <= 1'b1;
      flash_we_n_o    <= 1'b1;
      flash_dq_oe_n_o <= 1'b1;
      flash_addr_o    <= 16'h0000;
      flash_dq_o      <= 16'h0000;
    end else begin
      flash_ce_n_o    <= !(state_d == S_WSETUP || state_d == S_WPULSE ||
                           state_d == S_RACC);
      flash_oe_n_o    <= !(state_d == S_RACC);
      flash_we_n_o    <= !(state_d == S_WPULSE);
      flash_dq_oe_n_o <= !(state_d == S_WSETUP || state_d == S_WPULSE ||
                           state_d == S_WREC);
      if (state_d == S_WSETUP) begin
        flash_addr_o <= step_word[31:16];
        flash_dq_o   <= step_word[15:0];
      end else if (state_d == S_RACC && state_q == S_IDLE) begin
        flash_addr_o <= addr_q;
      end
    end
  end

  // Read capture on the last access cycle; repeated reads show polling
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i)
      rdata_q <= 16'h0000;
    else if (state_q == S_RACC && cnt_q == 24'h000000)
      rdata_q <= flash_dq_i;
  end

  // Host view of identification mode, cleared by either exit form
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i)
      idmode_q <= 1'b0;
    else if (state_q == S_PAUSE && cnt_q == 24'h000000)
      idmode_q <= (cmd_q == CMD_ID_ENTRY) ? 1'b1 :
                  (cmd_q == CMD_LOCKOUT) ? idmode_q : 1'b0;
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  a_prog_third_write: assert property (
    $fell(flash_we_n_o) && cmd_q == CMD_PROGRAM && step_q == 3'h2
    |-> flash_addr_o == UNLOCK_ADDR1 && flash_dq_o[7:0] == CODE_PROGRAM)
    else $error("program code write wrong");

  a_chip_erase_final: assert property (
    $fell(flash_we_n_o) && cmd_q == CMD_CHIP_ERASE && step_q == 3'h5
    |-> flash_addr_o == UNLOCK_ADDR1 && flash_dq_o[7:0] == CODE_CHIP)
    else $error("chip erase final write wrong");

  a_main_erase_final: assert property (
    $fell(flash_we_n_o) && cmd_q == CMD_MAIN_ERASE && step_q == 3'h5
    |-> flash_dq_o[7:0] == CODE_MAIN ##1 !flash_we_n_o ##1 flash_we_n_o)
    else $error("main erase final write wrong");

  a_lock_pause_quiet: assert property (
    $rose(state_q == S_PAUSE) && cmd_q == CMD_LOCKOUT
    |-> cnt_q == 24'(LOCK_PAUSE - 1) && flash_ce_n_o && flash_we_n_o)
    else $error("lockout pause not taken");

  a_id_entry_pause: assert property (
    $fell(flash_we_n_o) && cmd_q == CMD_ID_ENTRY && step_q == 3'h2
    |-> flash_dq_o[7:0] == CODE_ID_IN ##[3:5] state_q == S_PAUSE)
    else $error("id entry sequence wrong");

  a_id_exit_hold: assert property (
    state_q == S_PAUSE && cmd_q == CMD_ID_EXIT && cnt_q != 24'h000000
    |-> flash_ce_n_o && !start ##1 state_q == S_PAUSE)
    else $error("id exit pause broken");

endmodule : flash_host

// >>> testbench/flash_model.sv
// Behavioural parallel NOR flash answering the host's pins
`timescale 1ns/1ns
module flash_model #(
  parameter logic [15:0] MFR_CODE   = 16'h0011, // Arbitrary value
  parameter logic [15:0] DEV_CODE   = 16'h0022, // Arbitrary value
  parameter int          BUSY_READS = 3
) (
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] dq_i,
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic        elevated_id_voltage_i,
  output logic [15:0]      dq_o
);
  logic [15:0] mem [0:65535];
  logic        id_q   = 1'b0; // Power-up in array read
  logic        lock_q = 1'b0;
  logic        tg_q   = 1'b0;
  logic [15:0] v;
  int          st     = 0;
  int          busy   = 0;
  wire         a1     = addr_i[14:0] == 15'h5555;
  wire         a2     = addr_i[14:0] == 15'h2AAA;
  wire  [7:0]  c      = dq_i[7:0];

  // Erased array at power-up
  initial begin
    for (int i = 0; i < 65536; i++)
      mem[i] = 16'hFFFF;
    dq_o = 16'h0000;
  end

  // Command decoder; a wrong step drops back to idle
  always @(negedge we_n_i) begin
    if (!ce_n_i && oe_n_i) begin
      case (st)
        0: begin
          if (c == 8'hF0)
            id_q = 1'b0;
          st = (a1 && c == 8'hAA) ? 1 : 0;
        end
        1: st = (a2 && c == 8'h55) ? 2 : 0;
        2: begin
          if (a1 && c == 8'h90)
            id_q = 1'b1;
          if (a1 && c == 8'hF0)
            id_q = 1'b0;
          st = (a1 && c == 8'hA0) ? 3 : (a1 && c == 8'h80) ? 4 : 0;
        end
        3: begin
          if (!(lock_q && addr_i < 16'h2000))
            mem[addr_i] = mem[addr_i] & dq_i;
          busy = BUSY_READS;
          st = 0;
        end
        4: st = (a1 && c == 8'hAA) ? 5 : 0;
        5: st = (a2 && c == 8'h55) ? 6 : 0;
        default: begin
          if (a1 && (c == 8'h10 || c == 8'h30)) begin
            for (int i = 0; i < 65536; i++)
              if ((c == 8'h10 && !lock_q) || i >= 16'h2000)
                mem[i] = 16'hFFFF;
            busy = BUSY_READS;
          end
          if (a1 && c == 8'h40)
            lock_q = 1'b1;
          st = 0;
        end
      endcase
    end
  end

  // Read after an access delay; status bits while an operation runs
  always @(negedge oe_n_i) begin
    #10;
    if (!ce_n_i) begin
      v = mem[addr_i];
      if (id_q && addr_i[15:1] == 15'h0000)
        v = addr_i[0] ? DEV_CODE : MFR_CODE;
      else if (id_q && addr_i == 16'h0002)
        v = lock_q ? 16'h00FF : 16'h00FE;
      else if (elevated_id_voltage_i &&
               {addr_i[15:10], addr_i[8:1]} == 14'h0000)
        v = addr_i[0] ? DEV_CODE : MFR_CODE;
      if (busy > 0) begin
        tg_q = ~tg_q;
        v = {~v[15], tg_q, v[13:8], ~v[7], tg_q, v[5:0]};
        busy--;
      end
      dq_o = v;
    end
  end

  // Released bus must not keep the last word
  always @(posedge oe_n_i)
    dq_o = ~dq_o;
endmodule : flash_model

// >>> testbench/test_flash_host.sv
// Self-checking bench for the APB flash host against a flash model
`timescale 1ns/1ns
`define CHK(what, exp, got) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
      n_fail++; \
      $display("mismatch %s exp %h got %h", what, exp, got); \
    end \
  end
module test_flash_host;
  import flash_host_pkg::*;
  localparam logic [15:0] MFR  = 16'h0011; // Arbitrary value
  localparam logic [15:0] DEV  = 16'h0022; // Arbitrary value
  localparam int          BUSY = 3;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] faddr;
  logic [15:0] fdq;
  logic [15:0] dev_dq;
  logic        dq_oe_n;
  logic        ce_n;
  logic        oe_n;
  logic        we_n;
  logic [31:0] rd;
  logic        er;
  logic        tgx = 1'b0;
  logic        hv_id = 1'b0;
  logic [31:0] lf = 32'hFF5C;
  logic [15:0] a;
  int          n_fail = 0;
  int          checks_done = 0;
  // Wire level from whoever drives it
  wire  [15:0] dq_wire = dq_oe_n ? dev_dq : fdq;

  flash_host #(.LOCK_PAUSE(20)) i_dut (
    .mclk_i(mclk), .rst_i(rst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .flash_addr_o(faddr), .flash_dq_o(fdq), .flash_dq_i(dq_wire),
    .flash_dq_oe_n_o(dq_oe_n), .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n),
    .flash_we_n_o(we_n));

  flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV), .BUSY_READS(BUSY)) i_flash (
    .addr_i(faddr), .dq_i(dq_wire), .ce_n_i(ce_n), .oe_n_i(oe_n),
    .we_n_i(we_n), .elevated_id_voltage_i(hv_id), .dq_o(dev_dq));

  // 10 MHz clock
  initial begin
    forever #50 mclk = ~mclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Word seen while an operation runs, toggle state t
  function automatic logic [15:0] polled(input logic [15:0] v,
                                         input logic t);
    return {~v[15], t, v[13:8], ~v[7], t, v[5:0]};
  endfunction : polled

  task automatic end_of_test;
    if (n_fail == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  // One APB transfer; request stands until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Start a command; unless it is a read, try to start another while busy; then wait
  task automatic run(input logic [15:0] ad, input logic [15:0] d,
                     input cmd_type c);
    apb(1'b1, OFF_ADDR, {16'h0000, ad});
    apb(1'b1, OFF_WDATA, {16'h0000, d});
    apb(1'b1, OFF_CTRL, {29'h0, c});
    if (c != CMD_READ) begin
      apb(1'b1, OFF_CTRL, {29'h0, CMD_READ});
      `CHK("busy refusal", 1'b1, er)
    end
    // An unknown busy bit keeps polling, so the watchdog catches it
    do
      apb(1'b0, OFF_STATUS, 32'h0);
    while (rd[STAT_BUSY_BIT] !== 1'b0);
  endtask : run

  task automatic fetch(input logic [15:0] ad);
    run(ad, 16'h0000, CMD_READ);
    apb(1'b0, OFF_RDATA, 32'h0);
  endtask : fetch

  // Busy reads then the true word
  task automatic settle(input logic [15:0] ad, input logic [15:0] x);
    for (int j = 0; j < BUSY; j++) begin
      tgx = ~tgx;
      fetch(ad);
      `CHK("busy read", polled(x, tgx), rd[15:0])
    end
    fetch(ad);
    `CHK("settled read", x, rd[15:0])
  endtask : settle

  // Watchdog, well beyond the expected run length
  initial begin
    repeat (80000) @(posedge mclk);
    n_fail++;
    end_of_test();
  end

  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    apb(1'b0, 8'h14, 32'h0);
    `CHK("unmapped refusal", 1'b1, er)
    run(16'h0000, 16'h0000, CMD_ID_ENTRY);
    `CHK("id flag", 1'b1, rd[STAT_IDMODE_BIT])
    fetch(16'h0000);
    `CHK("maker code", MFR, rd[15:0])
    fetch(16'h0001);
    `CHK("part code", DEV, rd[15:0])
    fetch(16'h0002);
    `CHK("lock status", 8'hFE, rd[7:0])
    run(16'h0000, 16'h0000, CMD_ID_EXIT);
    fetch(16'h0000);
    `CHK("array after exit", 16'hFFFF, rd[15:0])
    run(16'h0000, 16'h0000, CMD_ID_ENTRY);
    run(16'h3C5A, 16'h0000, CMD_ID_EXIT1);
    fetch(16'h0001);
    `CHK("array after F0", 16'hFFFF, rd[15:0])
    // Codes under the elevated level with no command sequence
    hv_id <= 1'b1;
    fetch(16'h0001);
    `CHK("part code high voltage", DEV, rd[15:0])
    fetch(16'h0000);
    `CHK("maker code high voltage", MFR, rd[15:0])
    hv_id <= 1'b0;
    // Boundary address first, then random words in the main array
    for (int k = 0; k < 4; k++) begin
      lf = lfsr(lf);
      a = (k == 0) ? 16'h2000 : (lf[15:0] | 16'h2000);
      run(a, (k == 0) ? 16'h807F : lf[31:16], CMD_PROGRAM);
      settle(a, (k == 0) ? 16'h807F : lf[31:16]);
      run(16'h0000, 16'h0000, CMD_MAIN_ERASE);
      settle(a, 16'hFFFF);
    end
    run(16'h0010, 16'h1234, CMD_PROGRAM);
    settle(16'h0010, 16'h1234);
    run(16'h0000, 16'h0000, CMD_CHIP_ERASE);
    settle(16'h0010, 16'hFFFF);
    run(16'h0010, 16'h00F0, CMD_PROGRAM);
    settle(16'h0010, 16'h00F0);
    run(16'h0000, 16'h0000, CMD_LOCKOUT);
    run(16'h0000, 16'h0000, CMD_ID_ENTRY);
    fetch(16'h0002);
    `CHK("lock status set", 8'hFF, rd[7:0])
    run(16'h0000, 16'h0000, CMD_ID_EXIT1);
    run(16'h0000, 16'h0000, CMD_MAIN_ERASE);
    settle(16'h0010, 16'h00F0);
    run(16'h0000, 16'h0000, CMD_CHIP_ERASE);
    settle(16'h0010, 16'h00F0);
    run(16'h0010, 16'h0000, CMD_PROGRAM);
    settle(16'h0010, 16'h00F0);
    end_of_test();
  end
endmodule : test_flash_host
